// [design/uied_pkg.sv]
// Constants shared by the interrupt enable and disable command block
package uied_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] UIED_ADDR_MODE    = 32'hf801c004;
    localparam logic [31:0] UIED_ADDR_ENABLE  = 32'hf801c008;
    localparam logic [31:0] UIED_ADDR_DISABLE = 32'hf801c00c;
    localparam logic [31:0] UIED_ADDR_MASK    = 32'hf801c010;
    localparam logic [31:0] UIED_ADDR_STATUS  = 32'hf801c014;

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int UIED_MODE_LSB   = 0;
    localparam int UIED_MODE_MSB   = 3;
    localparam int UIED_CSS_LSB    = 4;
    localparam int UIED_CSS_MSB    = 5;
    localparam int UIED_CLK_OUT_BIT   = 18;
    localparam int UIED_WAIT_READ_BIT = 20;

    localparam logic [3:0] UIED_MODE_NORMAL     = 4'h0;
    localparam logic [3:0] UIED_MODE_LIN_MASTER = 4'ha;
    localparam logic [3:0] UIED_MODE_LIN_SLAVE  = 4'hb;
    localparam logic [3:0] UIED_MODE_SPI_MASTER = 4'he;
    localparam logic [3:0] UIED_MODE_SPI_SLAVE  = 4'hf;

    // Clock source codes: the reset value and the code that selects the external serial clock
    localparam logic [1:0] UIED_CSS_RESET    = 2'h0;
    localparam logic [1:0] UIED_CSS_EXTERNAL = 2'h3;

    // ------------------------------------------------------------------
    // Interrupt bit positions
    // ------------------------------------------------------------------
    localparam int UIED_BIT_RX_READY   = 0;
    localparam int UIED_BIT_TX_READY   = 1;
    localparam int UIED_BIT_RX_BREAK   = 2;
    localparam int UIED_BIT_OVERRUN    = 5;
    localparam int UIED_BIT_FRAMING    = 6;
    localparam int UIED_BIT_PARITY     = 7;
    localparam int UIED_BIT_TIMEOUT    = 8;
    localparam int UIED_BIT_TX_EMPTY   = 9;
    localparam int UIED_BIT_REPEAT_UNDERRUN = 10;
    localparam int UIED_BIT_NON_ACKNOWLEDGE_EVENT_BREAK = 13;
    localparam int UIED_BIT_LIN_ID     = 14;
    localparam int UIED_BIT_LIN_TC     = 15;
    localparam int UIED_BIT_CTS_SS     = 19;
    localparam int UIED_BIT_MANCHESTER = 24;
    localparam int UIED_BIT_LIN_BUS    = 25;
    localparam int UIED_BIT_LIN_SNR    = 29;

    // Bits that exist in each view
    localparam logic [31:0] UIED_VALID_NORMAL = 32'h010827e7;
    localparam logic [31:0] UIED_VALID_SPI    = 32'h00080623;
    localparam logic [31:0] UIED_VALID_LIN    = 32'h3e00e3e3;

    localparam logic [31:0] UIED_WORD_ZERO    = 32'h00000000;

endpackage

// [design/uied_edge_detect.sv]
// Two-stage pin synchroniser with a one-cycle edge pulse
`timescale 1ns/10ps
module uied_edge_detect (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_edge
);

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic [2:0] fill_q;

    // Only sync_q reads meta_q; edges are taken past the second stage
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edges wait until the pipe holds real samples: a pin idling high gives no false event after reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fill_q <= 3'h0;
        end else begin
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    // Rising and falling edges both count
    assign o_level = sync_q;
    assign o_edge  = (sync_q ^ last_q) & fill_q[2];

endmodule

// [design/uied_top.sv]
// Interrupt enable/disable command registers with mask, status and transmit options
`timescale 1ns/10ps
module uied_top
    import uied_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [31:0] i_event_pulse,
    input  wire logic        i_cts_pin,
    input  wire logic        i_lin_break_sent,
    input  wire logic        i_lin_break_rcvd,
    input  wire logic        i_lin_id_sent,
    input  wire logic        i_lin_id_rcvd,
    input  wire logic        i_serial_clk,
    input  wire logic        i_sck_in,
    output logic             o_sck_out,
    output logic             o_sck_oe,
    output logic             o_sck_in_sync,
    input  wire logic        i_thr_write,
    input  wire logic        i_tx_ready,
    input  wire logic        i_rx_ready,
    output logic             o_tx_start,
    output logic             o_irq
);

    // ------------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------------
    logic [3:0]  mode_q;
    logic [1:0]  css_q;
    logic        clk_out_q;
    logic        wait_read_q;
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] ev;
    logic [31:0] view_valid;
    logic        spi_mode;
    logic        lin_mode;
    logic        cts_edge;
    logic        pend_q;
    logic        take;
    logic        go;
    logic        setup;
    logic        wr_done;
    logic        en_wr;
    logic        dis_wr;
    logic        mode_wr;
    logic        stat_wr;
    logic        mapped;
    logic [31:0] rd_word;

    assign setup   = i_psel & ~i_penable;
    assign wr_done = i_psel & i_penable & o_pready & i_pwrite;
    assign en_wr   = wr_done & (i_paddr == UIED_ADDR_ENABLE);
    assign dis_wr  = wr_done & (i_paddr == UIED_ADDR_DISABLE);
    assign mode_wr = wr_done & (i_paddr == UIED_ADDR_MODE);
    assign stat_wr = wr_done & (i_paddr == UIED_ADDR_STATUS);

    assign spi_mode = (mode_q == UIED_MODE_SPI_MASTER) | (mode_q == UIED_MODE_SPI_SLAVE);
    assign lin_mode = (mode_q == UIED_MODE_LIN_MASTER) | (mode_q == UIED_MODE_LIN_SLAVE);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    uied_edge_detect u_cts_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_cts_pin),
        .o_level   (),
        .o_edge    (cts_edge)
    );

    uied_edge_detect u_sck_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_sck_in),
        .o_level   (o_sck_in_sync),
        .o_edge    ()
    );

    // ------------------------------------------------------------------
    // APB slave: zero wait states, answers in the access cycle
    // ------------------------------------------------------------------
    always_comb begin
        mapped  = 1'b1;
        rd_word = UIED_WORD_ZERO;
        unique case (i_paddr)
            UIED_ADDR_MODE: begin
                rd_word[UIED_MODE_MSB:UIED_MODE_LSB] = mode_q;
                rd_word[UIED_CSS_MSB:UIED_CSS_LSB]   = css_q;
                rd_word[UIED_CLK_OUT_BIT]            = clk_out_q;
                rd_word[UIED_WAIT_READ_BIT]          = wait_read_q;
            end
            UIED_ADDR_MASK:    rd_word = mask_q;
            UIED_ADDR_STATUS:  rd_word = status_q;
            // Command registers are write-only and read as zero
            UIED_ADDR_ENABLE:  rd_word = UIED_WORD_ZERO;
            UIED_ADDR_DISABLE: rd_word = UIED_WORD_ZERO;
            default:           mapped  = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= UIED_WORD_ZERO;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            if (setup) begin
                o_prdata  <= i_pwrite ? UIED_WORD_ZERO : rd_word;
                // Writes to the read-only mask are refused too
                o_pslverr <= ~mapped | (i_pwrite & (i_paddr == UIED_ADDR_MASK));
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode and option register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q      <= UIED_MODE_NORMAL;
            css_q       <= UIED_CSS_RESET;
            clk_out_q   <= 1'b0;
            wait_read_q <= 1'b0;
        end else if (mode_wr) begin
            mode_q      <= i_pwdata[UIED_MODE_MSB:UIED_MODE_LSB];
            css_q       <= i_pwdata[UIED_CSS_MSB:UIED_CSS_LSB];
            clk_out_q   <= i_pwdata[UIED_CLK_OUT_BIT];
            wait_read_q <= i_pwdata[UIED_WAIT_READ_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Bit layout of the active view
    // ------------------------------------------------------------------
    always_comb begin
        view_valid = UIED_VALID_NORMAL;
        if (spi_mode) begin
            view_valid = UIED_VALID_SPI;
        end else if (lin_mode) begin
            view_valid = UIED_VALID_LIN;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt mask
    // ------------------------------------------------------------------
    // Bits outside the active view keep their value across a mode change
    always_comb begin
        mask_d = mask_q;
        if (en_wr) begin
            mask_d = mask_q | (i_pwdata & view_valid);
        end else if (dis_wr) begin
            mask_d = mask_q & ~(i_pwdata & view_valid);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mask_q <= UIED_WORD_ZERO;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Event sources and sticky status
    // ------------------------------------------------------------------
    always_comb begin
        ev = i_event_pulse & view_valid;
        // Clear-to-send change in normal view, slave-select edge in SPI view
        ev[UIED_BIT_CTS_SS] = cts_edge & ~lin_mode;
        if (lin_mode) begin
            ev[UIED_BIT_NON_ACKNOWLEDGE_EVENT_BREAK] = i_lin_break_sent | i_lin_break_rcvd;
            ev[UIED_BIT_LIN_ID]     = i_lin_id_sent | i_lin_id_rcvd;
        end
    end

    // A new event wins over a write-one clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (stat_wr) begin
            status_d = status_q & ~i_pwdata;
        end
        status_d = status_d | ev;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            status_q <= UIED_WORD_ZERO;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_q & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Serial clock pin
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sck_oe  <= 1'b0;
            o_sck_out <= 1'b0;
        end else begin
            o_sck_oe  <= clk_out_q & (css_q != UIED_CSS_EXTERNAL);
            o_sck_out <= i_serial_clk;
        end
    end

    // ------------------------------------------------------------------
    // Transmit start gating
    // ------------------------------------------------------------------
    // A write while transmit-ready is low is not accepted here
    assign take = i_thr_write & i_tx_ready;
    assign go   = (take | pend_q) & (~wait_read_q | ~i_rx_ready);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_q     <= 1'b0;
            o_tx_start <= 1'b0;
        end else begin
            pend_q     <= (take | pend_q) & ~go;
            o_tx_start <= go;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sck_drive_a: assert property (
        (clk_out_q && css_q != UIED_CSS_EXTERNAL) ##1 (clk_out_q && css_q != UIED_CSS_EXTERNAL) |-> o_sck_oe
    ) else $error("serial clock pin not driven");

    sck_release_a: assert property (
        !clk_out_q |=> !o_sck_oe
    ) else $error("serial clock pin driven with option clear");

    start_nowait_a: assert property (
        (take && !wait_read_q) |=> o_tx_start
    ) else $error("transmit start missing without wait-read");

    start_hold_a: assert property (
        (wait_read_q && i_rx_ready && take) |=> !o_tx_start ##0 pend_q
    ) else $error("transmit started while receive-ready set");

    enable_set_a: assert property (
        en_wr |=> ((mask_q & $past(i_pwdata & view_valid)) == $past(i_pwdata & view_valid))
            && ((mask_q & ~$past(i_pwdata)) == ($past(mask_q) & ~$past(i_pwdata)))
    ) else $error("enable command did not set mask bits");

    normal_view_a: assert property (
        (en_wr && !spi_mode && !lin_mode) |=> ((mask_q & ~UIED_VALID_NORMAL) == $past(mask_q & ~UIED_VALID_NORMAL))
    ) else $error("normal view touched a missing bit");

    spi_view_a: assert property (
        (en_wr && spi_mode) |=> ((mask_q & ~UIED_VALID_SPI) == $past(mask_q & ~UIED_VALID_SPI))
    ) else $error("SPI view touched a missing bit");

    lin_view_a: assert property (
        (en_wr && lin_mode && i_pwdata[UIED_BIT_LIN_SNR] && i_pwdata[UIED_BIT_LIN_BUS])
            |=> mask_q[UIED_BIT_LIN_SNR] && mask_q[UIED_BIT_LIN_BUS]
    ) else $error("LIN enable bits not set");

    disable_clr_a: assert property (
        dis_wr |=> ((mask_q & $past(i_pwdata & view_valid)) == UIED_WORD_ZERO)
            && ((mask_q & ~$past(i_pwdata)) == ($past(mask_q) & ~$past(i_pwdata)))
    ) else $error("disable command did not clear mask bits");

    ss_edge_a: assert property (
        (spi_mode && cts_edge) |=> status_q[UIED_BIT_CTS_SS]
    ) else $error("slave-select edge not recorded");

    lin_both_a: assert property (
        (lin_mode && (i_lin_break_sent || i_lin_break_rcvd)) |=> status_q[UIED_BIT_NON_ACKNOWLEDGE_EVENT_BREAK]
    ) else $error("LIN break event not recorded");

    mask_read_a: assert property (
        (i_psel && i_penable && o_pready && !i_pwrite && i_paddr == UIED_ADDR_MASK) |-> o_prdata == mask_q
    ) else $error("mask readback wrong");

    irq_level_a: assert property (
        (|(status_q & mask_q)) |=> o_irq ##1 ((|$past(status_q & mask_q)) == o_irq)
    ) else $error("interrupt output does not follow status and mask");

endmodule

// [test/testbench.sv]
// Self-checking bench for the interrupt enable and disable command block
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end

module testbench;
    import uied_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk         = 1'b0;
    logic        sys_rst     = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [31:0] paddr       = 32'h00000000;
    logic [31:0] pwdata      = 32'h00000000;
    logic [31:0] event_pulse = 32'h00000000;
    logic        cts_pin     = 1'b0;
    logic [3:0]  lin_pulse   = 4'h0;
    logic        serial_clk  = 1'b0;
    logic        sck_in      = 1'b0;
    logic        thr_write   = 1'b0;
    logic        tx_ready    = 1'b0;
    logic        rx_ready    = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sck_out;
    logic        sck_oe;
    logic        sck_in_sync;
    logic        tx_start;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          errors       = 0;
    int          total_checks = 0;
    int          starts;
    // Mode codes and the enable layout each one must expose
    logic [3:0]  modes [6] = '{4'ha, 4'hb, 4'he, 4'hf, 4'h2, 4'h0};
    logic [31:0] views [6] = '{32'h3e00e3e3, 32'h3e00e3e3, 32'h00080623, 32'h00080623, 32'h010827e7, 32'h010827e7};
    logic [1:0]  sck_css [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
    logic        sck_drive [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic        sck_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

    always #12.5 clk = ~clk;

    uied_top dut_u (
        .i_clk            (clk),
        .i_sys_rst        (sys_rst),
        .i_psel           (psel),
        .i_penable        (penable),
        .i_pwrite         (pwrite),
        .i_paddr          (paddr),
        .i_pwdata         (pwdata),
        .o_prdata         (prdata),
        .o_pready         (pready),
        .o_pslverr        (pslverr),
        .i_event_pulse    (event_pulse),
        .i_cts_pin        (cts_pin),
        .i_lin_break_sent (lin_pulse[0]),
        .i_lin_break_rcvd (lin_pulse[1]),
        .i_lin_id_sent    (lin_pulse[2]),
        .i_lin_id_rcvd    (lin_pulse[3]),
        .i_serial_clk     (serial_clk),
        .i_sck_in         (sck_in),
        .o_sck_out        (sck_out),
        .o_sck_oe         (sck_oe),
        .o_sck_in_sync    (sck_in_sync),
        .i_thr_write      (thr_write),
        .i_tx_ready       (tx_ready),
        .i_rx_ready       (rx_ready),
        .o_tx_start       (tx_start),
        .o_irq            (irq)
    );

    // ------------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------------
    // The request is held until pready is seen high at an edge; only the bench timeout ends the wait
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h00000000);
        `CHK(rd, exp)
    endtask

    task automatic set_mode(input logic [3:0] m, input logic [1:0] css, input logic clk_out, input logic wait_read);
        wr(UIED_ADDR_MODE, {11'h000, wait_read, 1'b0, clk_out, 12'h000, css, m});
    endtask

    // Ends mid-cycle so that outputs read afterwards have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pulse_ev(input logic [31:0] v);
        @(posedge clk);
        event_pulse <= v;
        @(posedge clk);
        event_pulse <= 32'h00000000;
    endtask

    task automatic thr;
        @(posedge clk);
        thr_write <= 1'b1;
        @(posedge clk);
        thr_write <= 1'b0;
    endtask

    task automatic count_starts(input int n);
        starts = 0;
        repeat (n) begin
            @(negedge clk);
            if (tx_start === 1'b1) starts++;
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(UIED_ADDR_MASK, 32'h00000000);
        rd_chk(UIED_ADDR_MODE, 32'h00000000);
        `CHK(irq, 1'b0)
        $display("test reset done");

        wr(UIED_ADDR_ENABLE, 32'hffffffff);
        rd_chk(UIED_ADDR_MASK, 32'h010827e7);
        wr(UIED_ADDR_ENABLE, 32'h00000000);
        rd_chk(UIED_ADDR_MASK, 32'h010827e7);
        wr(UIED_ADDR_DISABLE, 32'h01082021);
        rd_chk(UIED_ADDR_MASK, 32'h000007c6);
        rd_chk(UIED_ADDR_ENABLE, 32'h00000000);
        `CHK(err, 1'b0)
        rd_chk(UIED_ADDR_DISABLE, 32'h00000000);
        wr(UIED_ADDR_MASK, 32'hffffffff);
        `CHK(err, 1'b1)
        rd_chk(UIED_ADDR_MASK, 32'h000007c6);
        apb(1'b0, 32'hf801c0f0, 32'h00000000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h00000000)
        wr(UIED_ADDR_DISABLE, 32'hffffffff);
        $display("test normal view done");

        for (int i = 0; i < 6; i++) begin
            set_mode(modes[i], UIED_CSS_RESET, 1'b0, 1'b0);
            wr(UIED_ADDR_ENABLE, 32'hffffffff);
            rd_chk(UIED_ADDR_MASK, views[i]);
            wr(UIED_ADDR_DISABLE, 32'hffffffff);
            rd_chk(UIED_ADDR_MASK, 32'h00000000);
        end
        $display("test mode views done");

        wr(UIED_ADDR_ENABLE, 32'h00000020);
        pulse_ev(32'h00000060);
        cyc(3);
        `CHK(irq, 1'b1)
        rd_chk(UIED_ADDR_STATUS, 32'h00000060);
        wr(UIED_ADDR_STATUS, 32'h00000020);
        cyc(3);
        `CHK(irq, 1'b0)
        wr(UIED_ADDR_ENABLE, 32'h00000040);
        cyc(3);
        `CHK(irq, 1'b1)
        wr(UIED_ADDR_DISABLE, 32'h00000040);
        cyc(3);
        `CHK(irq, 1'b0)
        wr(UIED_ADDR_STATUS, 32'h00000040);
        rd_chk(UIED_ADDR_STATUS, 32'h00000000);
        $display("test interrupt done");

        set_mode(UIED_MODE_SPI_MASTER, UIED_CSS_RESET, 1'b0, 1'b0);
        wr(UIED_ADDR_ENABLE, 32'h00080000);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            cts_pin <= ~cts_pin;
            cyc(8);
            `CHK(irq, 1'b1)
            rd_chk(UIED_ADDR_STATUS, 32'h00080000);
            wr(UIED_ADDR_STATUS, 32'h00080000);
            cyc(3);
            `CHK(irq, 1'b0)
        end
        wr(UIED_ADDR_DISABLE, 32'hffffffff);
        $display("test slave select done");

        set_mode(UIED_MODE_LIN_MASTER, UIED_CSS_RESET, 1'b0, 1'b0);
        wr(UIED_ADDR_ENABLE, 32'h00006000);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            lin_pulse <= 4'h1 << k;
            @(posedge clk);
            lin_pulse <= 4'h0;
            cyc(3);
            `CHK(irq, 1'b1)
            rd_chk(UIED_ADDR_STATUS, (k < 2) ? 32'h00002000 : 32'h00004000);
            wr(UIED_ADDR_STATUS, 32'h00006000);
        end
        wr(UIED_ADDR_DISABLE, 32'hffffffff);
        $display("test lin events done");

        // Receive-ready stays high to show it is ignored while the wait option is clear
        set_mode(UIED_MODE_NORMAL, UIED_CSS_RESET, 1'b0, 1'b0);
        tx_ready <= 1'b1;
        rx_ready <= 1'b1;
        thr();
        @(negedge clk);
        `CHK(tx_start, 1'b1)
        @(negedge clk);
        `CHK(tx_start, 1'b0)
        set_mode(UIED_MODE_NORMAL, UIED_CSS_RESET, 1'b0, 1'b1);
        thr();
        count_starts(6);
        `CHK(starts, 0)
        @(posedge clk);
        rx_ready <= 1'b0;
        count_starts(4);
        `CHK(starts, 1)
        // A holding write while transmit-ready is low is not taken
        @(posedge clk);
        tx_ready <= 1'b0;
        thr();
        count_starts(4);
        `CHK(starts, 0)
        $display("test transmit done");

        for (int i = 0; i < 4; i++) begin
            set_mode(UIED_MODE_NORMAL, sck_css[i], sck_drive[i], 1'b0);
            cyc(2);
            `CHK(sck_oe, sck_exp[i])
        end
        @(posedge clk);
        serial_clk <= 1'b1;
        sck_in     <= 1'b1;
        cyc(4);
        `CHK(sck_out, 1'b1)
        `CHK(sck_in_sync, 1'b1)
        $display("test serial clock done");

        wr(UIED_ADDR_ENABLE, 32'hffffffff);
        pulse_ev(32'h00000001);
        cyc(3);
        `CHK(irq, 1'b1)
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(UIED_ADDR_MASK, 32'h00000000);
        rd_chk(UIED_ADDR_STATUS, 32'h00000000);
        `CHK(irq, 1'b0)
        $display("test second reset done");
        summarize();
    end

    initial begin
        #500000;
        errors++;
        $display("watchdog expired at %0t ns", $time);
        summarize();
    end
endmodule
